// >>> dv/tb.sv
// Self-checking bench of the sensor watchdog, scheduler and alarm
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam CC = 200;
  logic        clk = 0, rst = 1, sdn = 1, pull = 0, osw = 0, hyw = 0;
  logic [8:0]  adc = 0, wd = 0, res, osl, hyl;
  logic [2:0]  fsel = 0;
  logic        sdo, sdoe_n, bact, done, hit, osoe_n, scl, msda, hit_nt;
  logic [31:0] rs = 32'h08BFEC65;
  logic [8:0]  q[$];
  int          err_total = 0, comparisons = 0, cyc = 0, hits = 0, k, n;
  int          hits_nt = 0;
  wire         sda = msda & (sdoe_n | sdo);
  initial forever #25 clk = ~clk;
  tsb_i2c_master m (.clk(clk), .scl(scl), .sda(msda));
  tsb_sensor #(.CONV_CYC(CC), .TIMEOUT_CYC(100)) uut (.clk(clk), .rst(rst),
    .scl_in(scl), .sda_in(sda), .sda_out_ff(sdo), .sda_oe_n_ff(sdoe_n),
    .sda_pull_req(pull), .shutdown(sdn), .adc_sample(adc), .os_limit_wr(osw),
    .hyst_limit_wr(hyw), .limit_wdata(wd), .fault_sel(fsel),
    .temp_result_ff(res), .overtemp_limit_ff(osl), .hysteresis_limit_ff(hyl),
    .bus_active_ff(bact), .conv_busy_ff(), .conv_done_ff(done),
    .timeout_hit_ff(hit), .os_out_ff(), .os_oe_n_ff(osoe_n));
  // Variant without the bus-stuck timeout, on the same pins
  tsb_sensor #(.HAS_TIMEOUT(0), .CONV_CYC(CC), .TIMEOUT_CYC(100)) uut_nt (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out_ff(),
    .sda_oe_n_ff(), .sda_pull_req(pull), .shutdown(sdn), .adc_sample(adc),
    .os_limit_wr(osw), .hyst_limit_wr(hyw), .limit_wdata(wd),
    .fault_sel(fsel), .temp_result_ff(), .overtemp_limit_ff(),
    .hysteresis_limit_ff(), .bus_active_ff(), .conv_busy_ff(),
    .conv_done_ff(), .timeout_hit_ff(hit_nt), .os_out_ff(), .os_oe_n_ff());
  function automatic logic [8:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[8:0];
  endfunction
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One conversion with sample v, then the alarm pin two edges later
  task automatic conv(input logic [8:0] v, input logic os);
    k = 0;
    adc <= v;
    q.push_back(v);
    while (done !== 1'b1 && k < CC + 9)
    begin
      @(posedge clk);
      k++;
    end
    cmp(9'(k < CC + 9), 9'h001);
    repeat (2) @(posedge clk);
    cmp(9'(osoe_n), 9'(!os));
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      tally_and_finish();
    end
    if (hit === 1'b1)
      hits++;
    if (hit_nt === 1'b1)
      hits_nt++;
    if (done === 1'b1)
      cmp(res, q.size() ? q.pop_front() : 9'h1XX);
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    cmp(osl, 9'h0A0);
    cmp(hyl, 9'h096);
    sdn <= 0;
    repeat (3) conv(xs() & 9'h09F, 0);
    sdn <= 1;
    $display("test conversion done");
    @(posedge clk);
    sdn <= 0;
    repeat (3) m.frame(8'(xs()), 0, 100);
    q.push_back(adc);
    m.frame(8'(xs()), 0, 0);
    for (k = 0; k < CC + 9 && done !== 1'b1; k++) @(posedge clk);
    cmp(9'(k >= CC + 2 && k <= CC + 7), 9'h001);
    sdn <= 1;
    $display("test abort done");
    m.frame(8'(xs()), 150, 20);
    cmp(9'(hits), 9'h000);
    sdn <= 0;
    pull <= 1;
    q.push_back(adc);
    m.frame(8'(xs()), 150, 0);
    pull <= 0;
    cmp(9'(hits), 9'h001);
    repeat (CC) @(posedge clk);
    cmp(9'(q.size()), 9'h000);
    q.push_back(adc);
    // Last data bit high keeps every low run inside the frame short
    m.frame(8'(xs()) | 8'h01, 50, 0);
    repeat (CC + 10) @(posedge clk);
    sdn <= 1;
    cmp(9'(hits), 9'h001);
    cmp(9'(hits_nt), 9'h000);
    $display("test timeout done");
    wd <= 9'h1F6;
    osw <= 1;
    @(posedge clk);
    osw <= 0;
    wd <= 9'h1EC;
    hyw <= 1;
    @(posedge clk);
    hyw <= 0;
    @(posedge clk);
    cmp(osl, 9'h1F6);
    cmp(hyl, 9'h1EC);
    sdn <= 0;
    for (int s = 0; s < 8; s++)
    begin
      fsel <= 3'(s);
      n = (s == 0) ? 1 : (s > 6) ? 6 : s;
      for (int i = 0; i < n; i++) conv(9'h000, i == n - 1);
      for (int i = 0; i < n; i++) conv(9'h1CE, i != n - 1);
    end
    $display("test alarm done");
    tally_and_finish();
  end
endmodule

// >>> dv/tsb_i2c_master.sv
// Bus master model driving SCL and SDA toward the sensor
module tsb_i2c_master
(
  input  wire  clk,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic hc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Start, eight bits at 400 ns per SCL period, low hold, stop, gap
  task automatic frame(input logic [7:0] d, input int hold, input int gap);
    sda <= 1'b0;
    hc(4);
    for (int i = 7; i >= 0; i--)
    begin
      scl <= 1'b0;
      hc(2);
      sda <= d[i];
      hc(2);
      scl <= 1'b1;
      hc(4);
    end
    scl <= 1'b0;
    sda <= 1'b0;
    hc(4 + hold);
    scl <= 1'b1;
    hc(4);
    sda <= 1'b1;
    hc(gap);
  endtask
endmodule

// >>> dv/tsb_sensor_properties.sv
// Checker of timeout, scheduler and alarm timing at the sensor ports
module tsb_chk
#(parameter int TIMEOUT_CYC = 100)
(
  input wire       clk,
  input wire       rst,
  input wire       sda_in,
  input wire       shutdown,
  input wire [8:0] adc_sample,
  input wire [8:0] temp_result_ff,
  input wire       sda_oe_n_ff,
  input wire       bus_active_ff,
  input wire       conv_busy_ff,
  input wire       conv_done_ff,
  input wire       timeout_hit_ff,
  input wire       sda_out_ff,
  input wire       os_out_ff,
  input wire       os_oe_n_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  // Raw cycles of SDA low, ahead of the design's filter
  int low_ff;
  always @(posedge clk) low_ff <= (rst || sda_in) ? 0 : low_ff + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_result_load: assert property (
    conv_done_ff |-> temp_result_ff == $past(adc_sample)) else $error("load");
  chk_result_hold: assert property (
    !conv_done_ff |-> $stable(temp_result_ff)) else $error("result moved");
  chk_bus_abort: assert property (
    bus_active_ff |-> !conv_busy_ff && !conv_done_ff) else $error("abort");
  chk_conv_restart: assert property (
    $fell(bus_active_ff) && !shutdown |-> conv_busy_ff) else $error("restart");
  chk_stuck_release: assert property (
    timeout_hit_ff |-> sda_oe_n_ff && !bus_active_ff) else $error("release");
  chk_stuck_window: assert property (
    timeout_hit_ff |-> low_ff >= TIMEOUT_CYC && low_ff <= TIMEOUT_CYC + 6)
    else $error("timeout window");
  chk_stuck_off: assert property (
    timeout_hit_ff |-> !$past(shutdown)) else $error("timeout in shutdown");
  chk_alarm_time: assert property (
    $changed(os_oe_n_ff) |-> $past(conv_done_ff)) else $error("alarm time");
  chk_pins_low: assert property (
    !sda_out_ff && !os_out_ff) else $error("open drain level");
  cover property (timeout_hit_ff);
  cover property ($fell(os_oe_n_ff));
  cover property ($fell(bus_active_ff) && conv_busy_ff);
endmodule

bind tsb_sensor tsb_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.*);

// >>> verilog/tsb_fault_count.v
// Consecutive over-limit counter driving the overtemperature state
`include "tsb_map.vh"

module tsb_fault_count
#(
  parameter TW = `TSB_TEMP_W,
  parameter FW = `TSB_FAULT_W
)
(
  input  wire          clk,
  input  wire          rst,
  input  wire          sample_vld,
  input  wire [TW-1:0] sample,
  input  wire [TW-1:0] os_limit,
  input  wire [TW-1:0] hyst_limit,
  input  wire [FW-1:0] fault_sel,
  output reg           alarm_ff
);

  reg  [FW-1:0] cnt_ff;
  reg  [FW-1:0] nxt_cnt;
  reg           nxt_alarm;
  reg  [FW-1:0] need;
  wire          over;
  wire          under;

  // Signed compare on half-degree words
  assign over  = $signed(sample) > $signed(os_limit);
  assign under = $signed(sample) < $signed(hyst_limit);

  always @*
  begin
    nxt_cnt   = cnt_ff;
    nxt_alarm = alarm_ff;
    need      = fault_sel;
    if (fault_sel == {FW{1'b0}})
      need = {{(FW-1){1'b0}}, 1'b1};
    else if (fault_sel > `TSB_FAULT_MAX)
      need = `TSB_FAULT_MAX;
    if (sample_vld)
    begin
      if ((!alarm_ff && over) || (alarm_ff && under))
      begin
        nxt_cnt = cnt_ff + {{(FW-1){1'b0}}, 1'b1};
        if (nxt_cnt >= need)
        begin
          nxt_alarm = ~alarm_ff;
          nxt_cnt   = {FW{1'b0}};
        end
      end
      else
        nxt_cnt = {FW{1'b0}};
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff   <= {FW{1'b0}};
      alarm_ff <= 1'b0;
    end
    else
    begin
      cnt_ff   <= nxt_cnt;
      alarm_ff <= nxt_alarm;
    end
  end

endmodule

// >>> verilog/tsb_map.vh
// Constants for the temperature sensor bus and conversion scheduler
// Operation
// - SDA low beyond timeout window: abandon transfer, release SDA, await start
// - Timeout exists only on the variant that offers it
// - Result reads always show the last completed conversion
// - Bus access aborts conversion; fresh conversion starts after access ends
// - Accesses closer than one conversion time leave the result unchanged
// - Selectable count, up to six, of over-limit conversions before alarm
// - Limit registers load their defaults at power-up
// - Temperatures are 9-bit two's complement, LSB half a degree
// - Timeout detection is off in shutdown mode
// - Conversion takes about 100 ms, never more than 300 ms
`ifndef TSB_MAP_VH
`define TSB_MAP_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define TSB_CLK_KHZ        20000
`define TSB_CONV_TYP_MS    100
`define TSB_CONV_MAX_MS    300
`define TSB_TIMEOUT_MIN_MS 75
`define TSB_TIMEOUT_MAX_MS 325
// 100 ms and 75 ms at 20 MHz, sized to the 23-bit counters
`define TSB_CONV_CYC       23'h1E8480
`define TSB_TIMEOUT_CYC    23'h16E360
`define TSB_CNT_W          23

// ----------------------------------------------------------------
// Data format and defaults
// ----------------------------------------------------------------
`define TSB_TEMP_W         9
`define TSB_OS_DEFAULT     9'h0A0
`define TSB_HYST_DEFAULT   9'h096
`define TSB_FAULT_MAX      3'h6
`define TSB_FAULT_W        3

`endif

// >>> verilog/tsb_sensor.v
// Bus watchdog, conversion scheduler and limit store of the sensor
`include "tsb_map.vh"

module tsb_sensor
#(
  parameter            HAS_TIMEOUT = 1,
  parameter            CNT_W       = `TSB_CNT_W,
  parameter [CNT_W-1:0] CONV_CYC   = `TSB_CONV_CYC,
  parameter [CNT_W-1:0] TIMEOUT_CYC = `TSB_TIMEOUT_CYC,
  parameter            TW          = `TSB_TEMP_W,
  parameter            FW          = `TSB_FAULT_W
)
(
  input  wire          clk,
  input  wire          rst,
  input  wire          scl_in,
  input  wire          sda_in,
  output reg           sda_out_ff,
  output reg           sda_oe_n_ff,
  input  wire          sda_pull_req,
  input  wire          shutdown,
  input  wire [TW-1:0] adc_sample,
  input  wire          os_limit_wr,
  input  wire          hyst_limit_wr,
  input  wire [TW-1:0] limit_wdata,
  input  wire [FW-1:0] fault_sel,
  output reg  [TW-1:0] temp_result_ff,
  output reg  [TW-1:0] overtemp_limit_ff,
  output reg  [TW-1:0] hysteresis_limit_ff,
  output reg           bus_active_ff,
  output reg           conv_busy_ff,
  output reg           conv_done_ff,
  output reg           timeout_hit_ff,
  output reg           os_out_ff,
  output reg           os_oe_n_ff
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_XFER = 2'h1;
  localparam [1:0] ST_LOCK = 2'h2;

  reg  [2:0]       scl_sync_ff;
  reg  [2:0]       sda_sync_ff;
  reg              scl_f_ff;
  reg              sda_f_ff;
  reg              nxt_scl_f;
  reg              nxt_sda_f;
  reg  [1:0]       state_ff;
  reg  [1:0]       nxt_state;
  reg  [CNT_W-1:0] to_cnt_ff;
  reg  [CNT_W-1:0] nxt_to_cnt;
  reg  [CNT_W-1:0] conv_cnt_ff;
  reg  [CNT_W-1:0] nxt_conv_cnt;
  reg              nxt_conv_busy;
  reg              nxt_conv_done;
  reg              nxt_timeout;
  wire             start_cond;
  wire             stop_cond;
  wire             to_enable;
  wire             alarm;

  // A level counts once the second and third stages agree
  always @*
  begin
    nxt_scl_f = scl_f_ff;
    nxt_sda_f = sda_f_ff;
    if (scl_sync_ff[1] == scl_sync_ff[2])
      nxt_scl_f = scl_sync_ff[2];
    if (sda_sync_ff[1] == sda_sync_ff[2])
      nxt_sda_f = sda_sync_ff[2];
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_f_ff    <= 1'b1;
      sda_f_ff    <= 1'b1;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_in};
      scl_f_ff    <= nxt_scl_f;
      sda_f_ff    <= nxt_sda_f;
    end
  end

  assign start_cond = scl_f_ff && nxt_scl_f && sda_f_ff && !nxt_sda_f;
  assign stop_cond  = scl_f_ff && nxt_scl_f && !sda_f_ff && nxt_sda_f;

  // ----------------------------------------------------------------
  // Bus-stuck watchdog
  // ----------------------------------------------------------------
  // Only the timeout variant with the device awake watches SDA
  assign to_enable = (HAS_TIMEOUT != 0) && !shutdown;

  always @*
  begin
    nxt_to_cnt  = {CNT_W{1'b0}};
    nxt_timeout = 1'b0;
    if (to_enable && !sda_f_ff)
    begin
      if (to_cnt_ff >= TIMEOUT_CYC - {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        nxt_timeout = (to_cnt_ff == TIMEOUT_CYC -
                       {{(CNT_W-1){1'b0}}, 1'b1});
        // Park past the end so one low episode fires only once
        nxt_to_cnt  = TIMEOUT_CYC;
      end
      else
        nxt_to_cnt = to_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Serial interface state
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (start_cond)
          nxt_state = ST_XFER;
      ST_XFER:
        if (nxt_timeout)
          nxt_state = ST_LOCK;
        else if (stop_cond)
          nxt_state = ST_IDLE;
      ST_LOCK:
        if (start_cond)
          nxt_state = ST_XFER;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_ff       <= ST_IDLE;
      to_cnt_ff      <= {CNT_W{1'b0}};
      timeout_hit_ff <= 1'b0;
      bus_active_ff  <= 1'b0;
      sda_out_ff     <= 1'b0;
      sda_oe_n_ff    <= 1'b1;
    end
    else
    begin
      state_ff       <= nxt_state;
      to_cnt_ff      <= nxt_to_cnt;
      timeout_hit_ff <= nxt_timeout;
      bus_active_ff  <= (nxt_state == ST_XFER);
      sda_out_ff     <= 1'b0;
      // SDA is released whenever no transfer is running
      sda_oe_n_ff    <= !(sda_pull_req && nxt_state == ST_XFER);
    end
  end

  // ----------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_conv_cnt  = {CNT_W{1'b0}};
    nxt_conv_busy = 1'b0;
    nxt_conv_done = 1'b0;
    // Any access aborts and holds off conversion until it ends
    if (!shutdown && nxt_state != ST_XFER)
    begin
      nxt_conv_busy = 1'b1;
      if (conv_cnt_ff == CONV_CYC - {{(CNT_W-1){1'b0}}, 1'b1})
        nxt_conv_done = 1'b1;
      else
        nxt_conv_cnt = conv_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      conv_cnt_ff    <= {CNT_W{1'b0}};
      conv_busy_ff   <= 1'b0;
      conv_done_ff   <= 1'b0;
      temp_result_ff <= {TW{1'b0}};
    end
    else
    begin
      conv_cnt_ff  <= nxt_conv_cnt;
      conv_busy_ff <= nxt_conv_busy;
      conv_done_ff <= nxt_conv_done;
      // Result only moves on a finished conversion
      if (nxt_conv_done)
        temp_result_ff <= adc_sample;
    end
  end

  // ----------------------------------------------------------------
  // Limits and overtemperature output
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst)
    begin
      overtemp_limit_ff   <= `TSB_OS_DEFAULT;
      hysteresis_limit_ff <= `TSB_HYST_DEFAULT;
      os_out_ff           <= 1'b0;
      os_oe_n_ff          <= 1'b1;
    end
    else
    begin
      if (os_limit_wr)
        overtemp_limit_ff <= limit_wdata;
      if (hyst_limit_wr)
        hysteresis_limit_ff <= limit_wdata;
      os_out_ff  <= 1'b0;
      os_oe_n_ff <= !alarm;
    end
  end

  tsb_fault_count
  #(
    .TW (TW),
    .FW (FW)
  )
  u_fault
  (
    .clk        (clk),
    .rst        (rst),
    .sample_vld (nxt_conv_done),
    .sample     (adc_sample),
    .os_limit   (overtemp_limit_ff),
    .hyst_limit (hysteresis_limit_ff),
    .fault_sel  (fault_sel),
    .alarm_ff   (alarm)
  );

endmodule
